// file: verification/dcs_link_chk.sv
// Checker on the link wires between the host end and the master unit.
`timescale 1ns/1ps
module dcs_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link wires
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic        sck_q;
  logic        done;
  logic        seen;
  logic [5:0]  bits;
  logic [4:0]  fidx;
  logic [4:0]  dfidx;
  logic [39:0] smo;
  logic [39:0] smi;
  logic [39:0] fmo;
  logic [39:0] fmi;
  wire         rise = sck & ~sck_q;

  function automatic logic [5:0] crc6(input logic [39:0] f);
    logic [5:0] c;
    c = 6'h3f;
    for (int i = 39; i >= 7; i--) c = {c[4:0], 1'b0} ^ ((c[5] ^ f[i]) ? 6'h19 : 6'h00);
    return c;
  endfunction : crc6

  ////////////////////////////////////////////////////////////////////////
  // Frames are rebuilt from the wires, so nothing here trusts either end.
  always_ff @(posedge clk) begin
    sck_q <= sck;
    done  <= 1'b0;
    seen  <= seen | done;
    if (reset) begin
      bits <= 6'h00;
      fidx <= 5'h00;
      seen <= 1'b0;
    end else if (cs_n) begin
      bits <= 6'h00;
      fidx <= 5'h00;
    end else if (rise) begin
      smo <= {smo[38:0], mosi};
      smi <= {smi[38:0], miso};
      bits <= (bits == 6'h27) ? 6'h00 : bits + 6'h01;
      if (bits == 6'h27) begin
        fidx  <= fidx + 5'h01;
        dfidx <= fidx;
        fmo   <= {smo[38:0], mosi};
        fmi   <= {smi[38:0], miso};
        done  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_cmd_origin: assert property (done && dfidx == 5'h00 |-> fmo[39])
    else $error("command frame origin bit low");
  a_ans_origin: assert property (done |-> !fmi[39])
    else $error("answer frame origin bit high");
  a_cmd_crc: assert property (done && dfidx == 5'h00 |-> fmo[5:0] == crc6(fmo))
    else $error("command checksum wrong");
  // The first answer after reset precedes any command, so it carries no checksum.
  a_ans_crc: assert property (done && seen |-> fmi[5:0] == crc6(fmi))
    else $error("answer checksum wrong");
  a_frame_whole: assert property ($rose(cs_n) |-> bits == 6'h00 && fidx != 5'h00)
    else $error("select released inside a frame");
  a_gap_min: assert property ($rose(cs_n) |-> cs_n [*8] ##1 cs_n [*8])
    else $error("gap between frames too short");
  a_sck_idle: assert property ($fell(cs_n) |-> !sck && !$past(sck))
    else $error("serial clock not idle low at frame start");
  a_miso_stable: assert property (rise |-> $stable(miso))
    else $error("answer line moved at sampling edge");
endmodule : dcs_link_chk

// file: verification/tb_top.sv
// Testbench joining host end and master unit, driven through the host command port.
`timescale 1ns/1ps
module tb_top;
  localparam int NF = 4;
  logic        clk;
  logic        reset;
  logic        wr;
  logic        rd;
  logic [6:0]  addr;
  logic [39:0] wdata;
  logic [39:0] rdata;
  logic [39:0] v;
  logic        busy;
  logic        crc_error;
  logic        cmd_dropped;
  logic        burst_ready;
  logic [1:0]  gfs;
  logic [1:0]  speed;
  int          n_mismatch;
  int          cmp_count;
  int          cyc;
  int          n_drop;

  dcs_link_if lnk ();
  dcs_host #(.NUM_FRAMES(NF)) i_dcs_host (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .busy(busy), .crc_error(crc_error), .link(lnk.host));
  dcs_unit #(.NUM_FRAMES(NF), .UNIT_INDEX(5'h01)) i_dcs_unit (.clk(clk), .reset(reset), .link(lnk.unit),
    .global_fault_summary(gfs), .link_speed(speed), .cmd_dropped(cmd_dropped), .burst_ready(burst_ready));
  dcs_link_chk i_dcs_link_chk (.clk(clk), .reset(reset), .sck(lnk.sck), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
    .miso(lnk.miso));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  function automatic logic [39:0] cmd(input logic w, input logic [4:0] u, input logic [6:0] a,
                                      input logic [17:0] d);
    return {1'b1, w, u, a, 2'h0, d, 6'h00};
  endfunction : cmd

  function automatic logic [39:0] ans(input logic b, input logic [6:0] a, input logic [17:0] d);
    return {1'b0, b, 5'h01, a, gfs, d, 6'h00};
  endfunction : ans

  // One command through the host (NUM_FRAMES frames when a is 1), then the last received frame is read back into v.
  task automatic op(input logic [6:0] a, input logic [39:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk) #1;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk) #1;
    if (busy !== 1'b0) n_mismatch++;
    @(posedge clk);
    addr <= 7'h00;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : op

  // The checksum field is judged on the wire by the checker.
  task automatic cx(input logic [39:0] exp);
    check({v[39:6], 6'h00}, exp);
  endtask : cx

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cmd_dropped === 1'b1) n_drop++;
    // The fast burst wait alone takes 80000 cycles.
    if (cyc == 97000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 7'h00;
    wdata = 40'h0;
    gfs = 2'h2;
    speed = 2'h3;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    op(7'h00, cmd(1'b1, 5'h01, 7'h05, 18'h2a5a5));
    op(7'h00, cmd(1'b1, 5'h01, 7'h03, 18'h0c3c3));
    cx(ans(1'b0, 7'h05, 18'h2a5a5));
    op(7'h00, cmd(1'b0, 5'h01, 7'h05, 18'h15555));
    cx(ans(1'b0, 7'h03, 18'h0c3c3));
    op(7'h00, cmd(1'b1, 5'h01, 7'h5f, 18'h3ffff));
    cx(ans(1'b0, 7'h05, 18'h2a5a5));
    op(7'h00, cmd(1'b1, 5'h02, 7'h05, 18'h00000));
    cx(ans(1'b0, 7'h5f, 18'h3ffff));
    op(7'h00, cmd(1'b1, 5'h01, 7'h00, 18'h11111));
    op(7'h00, cmd(1'b1, 5'h01, 7'h01, 18'h22222));
    cx(ans(1'b0, 7'h00, 18'h11111));
    op(7'h00, cmd(1'b1, 5'h01, 7'h02, 18'h03333));
    cx(ans(1'b0, 7'h01, 18'h22222));
    $display("single access test done");
    op(7'h00, cmd(1'b0, 5'h01, 7'h60, 18'h00000));
    cx(ans(1'b0, 7'h02, 18'h03333));
    op(7'h00, cmd(1'b1, 5'h01, 7'h78, 18'h00000));
    check(40'(n_drop), 40'd3);
    op(7'h00, cmd(1'b0, 5'h01, 7'h05, 18'h00000));
    op(7'h00, cmd(1'b0, 5'h01, 7'h7a, 18'h00000));
    cx(ans(1'b0, 7'h05, 18'h2a5a5));
    $display("refusal test done");
    for (int i = 0; i < 90000 && burst_ready !== 1'b1; i++) @(posedge clk) #1;
    check({39'h0, burst_ready}, 40'h1);
    op(7'h01, cmd(1'b0, 5'h01, 7'h03, 18'h00000));
    cx(ans(1'b1, {2'b11, 5'(NF)}, 18'h0c3c3));
    op(7'h00, cmd(1'b0, 5'h01, 7'h05, 18'h00000));
    cx(ans(1'b0, 7'h03, 18'h0c3c3));
    check({39'h0, crc_error}, 40'h0);
    @(posedge clk);
    addr <= 7'h02;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, 40'h0);
    $display("burst test done");
    finish_test();
  end
endmodule : tb_top

// file: verilog/dcs_consts.svh
// Constants for the daisy chain SPI frame protocol: field positions, codes and timing.
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_FRAME_BITS      40
`define DCS_ORIGIN_BIT      39
`define DCS_BURST_BIT       38
`define DCS_RW_BIT          38
`define DCS_UNIT_HI         37
`define DCS_UNIT_LO         33
`define DCS_ADDR_HI         32
`define DCS_ADDR_LO         26
`define DCS_FAULT_HI        25
`define DCS_FAULT_LO        24
`define DCS_DATA_HI         23
`define DCS_DATA_LO         6
`define DCS_CRC_HI          5
`define DCS_CRC_LO          0
`define DCS_CRC_SEED        6'h3f
`define DCS_CRC_POLY        6'h19
`define DCS_ADDR_MAX        7'h5f
`define DCS_BURST_FIRST     7'h78
`define DCS_BURST_LAST      7'h7d
`define DCS_BURST_CELLS     7'h78
`define DCS_BURST_DIAG      7'h7a
`define DCS_BURST_COUNT     7'h7b
`define DCS_BURST_FRAMES    20
`define DCS_SPEED_FAST      2'h3
`define DCS_SPEED_SLOW      2'h0
`define DCS_WAIT_FAST_US    400
`define DCS_WAIT_SLOW_US    3000
`define DCS_CLK_MHZ         200
`define DCS_WAIT_FAST_CYC   (`DCS_WAIT_FAST_US * `DCS_CLK_MHZ)
`define DCS_WAIT_SLOW_CYC   (`DCS_WAIT_SLOW_US * `DCS_CLK_MHZ)
`define DCS_SCK_HALF        8
`define DCS_GAP_CYC         16
`endif

// file: verilog/dcs_host.sv
// Host end: runs single and burst frames on the link from a plain command port.
`timescale 1ns/1ps
`include "dcs_consts.svh"
module dcs_host import dcs_pkg::*; #(
  parameter int unsigned NUM_FRAMES = `DCS_BURST_FRAMES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command port
  input  wire logic [6:0]  addr,
  input  wire logic [39:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [39:0]      rdata,
  output logic             busy,
  output logic             crc_error,
  // Link pins
  dcs_link_if.host         link
);
  typedef enum logic [1:0] {
    DCS_IDLE = 2'b00,
    DCS_SHIFT = 2'b01,
    DCS_GAP = 2'b10
  } dcs_state_t;
  ////////////////////////////////////////////////////////////////////////
  dcs_state_t  state, next_state;
  logic [39:0] tx, next_tx;
  logic [39:0] rx, next_rx;
  logic [39:0] last, next_last;
  logic [39:0] cmd_frame, next_cmd_frame;
  logic [6:0]  bit_cnt, next_bit_cnt;
  logic [3:0]  div, next_div;
  logic [4:0]  frames, next_frames;
  logic        sck, next_sck;
  logic        cs_n, next_cs_n;
  logic        err, next_err;
  logic [1:0]  miso_sync;
  logic [39:0] done_frm;
  always_ff @(posedge clk) begin
    if (reset) begin
      miso_sync <= 2'b00;
    end else begin
      miso_sync <= {miso_sync[0], link.miso};
    end
  end
  assign done_frm = {rx[38:0], miso_sync[1]};

  // Port: write addr 0 sends a frame (seals bit 39 and the checksum);
  // write addr 1 sends the frame then NUM_FRAMES-1 repeats of it for a burst.
  always_comb begin
    next_state   = state;
    next_tx      = tx;
    next_rx      = rx;
    next_last    = last;
    next_cmd_frame = cmd_frame;
    next_bit_cnt = bit_cnt;
    next_div     = div;
    next_frames  = frames;
    next_sck     = sck;
    next_cs_n    = cs_n;
    next_err     = err;
    case (state)
      DCS_IDLE: begin
        if (wr && addr <= 7'h01) begin
          next_tx = {1'b1, wdata[38:6], 6'h00};
          next_tx[5:0] = dcs_crc(next_tx);
          next_cmd_frame = next_tx;
          next_frames  = (addr == 7'h01) ? 5'(NUM_FRAMES) : 5'h01;
          next_cs_n    = 1'b0;
          next_bit_cnt = 7'h00;
          next_div     = 4'h0;
          next_state   = DCS_SHIFT;
        end
      end
      DCS_SHIFT: begin
        next_div = div + 4'h1;
        if (div == 4'(`DCS_SCK_HALF - 1)) begin
          next_div = 4'h0;
          next_sck = ~sck;
          if (!sck) begin
            next_rx = done_frm;
          end else begin
            next_tx = {tx[38:0], 1'b0};
            next_bit_cnt = bit_cnt + 7'h01;
            if (bit_cnt == 7'(`DCS_FRAME_BITS - 1)) begin
              next_bit_cnt = 7'h00;
              next_last    = rx;
              next_err     = rx[5:0] != dcs_crc(rx);
              next_frames  = frames - 5'h01;
              // Every later burst frame repeats the command: the unit ignores the middle ones
              // and decodes the last.
              if (frames == 5'h01) begin
                next_cs_n  = 1'b1;
                next_state = DCS_GAP;
              end else begin
                next_tx = cmd_frame;
              end
            end
          end
        end
      end
      default: begin
        // Same gap after every single frame or whole burst, read or write.
        next_div = div + 4'h1;
        if (div == 4'(`DCS_GAP_CYC - 1)) begin
          next_state = DCS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= DCS_IDLE;
      tx      <= 40'h0;
      rx      <= 40'h0;
      last    <= 40'h0;
      cmd_frame <= 40'h0;
      bit_cnt <= 7'h00;
      div     <= 4'h0;
      frames  <= 5'h00;
      sck     <= 1'b0;
      cs_n    <= 1'b1;
      err     <= 1'b0;
      rdata   <= 40'h0;
    end else begin
      state   <= next_state;
      tx      <= next_tx;
      rx      <= next_rx;
      last    <= next_last;
      cmd_frame <= next_cmd_frame;
      bit_cnt <= next_bit_cnt;
      div     <= next_div;
      frames  <= next_frames;
      sck     <= next_sck;
      cs_n    <= next_cs_n;
      err     <= next_err;
      if (rd) begin
        rdata <= (addr == 7'h02) ? {38'h0, err, state != DCS_IDLE} : last;
      end
    end
  end

  // The burst wait of 400 us or 3 ms is left to software between the burst command and download.
  assign busy      = state != DCS_IDLE;
  assign crc_error = err;
  assign link.sck  = sck;
  assign link.cs_n = cs_n;
  assign link.mosi = tx[39];
endmodule : dcs_host

// file: verilog/dcs_link_if.sv
// Four-wire SPI link between the host and the master unit of the chain.
`timescale 1ns/1ps
interface dcs_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;

  modport host (output sck, output cs_n, output mosi, input miso);
  modport unit (input sck, input cs_n, input mosi, output miso);
endinterface : dcs_link_if

// file: verilog/dcs_pkg.sv
// Types shared by both ends of the daisy chain SPI frame link.
package dcs_pkg;
  typedef logic [39:0] dcs_frame_t;
  typedef logic [5:0]  dcs_crc_t;

  function automatic dcs_crc_t dcs_crc(input dcs_frame_t f);
    logic [5:0] c;
    c = 6'h3f;
    for (int i = 39; i >= 7; i--) begin
      if (c[5] ^ f[i]) begin
        c = {c[4:0], 1'b0} ^ 6'h19;
      end else begin
        c = {c[4:0], 1'b0};
      end
    end
    return c;
  endfunction : dcs_crc
endpackage : dcs_pkg

// file: verilog/dcs_unit.sv
// Master unit of the chain: frame decode, register store, reply buffer and burst buffer.
//
// How it works
// - Reply to frame N shifts out in N+1.
// - Replies are buffered, sent on next command.
// - Write answer echoes the freshly written register.
// - Host keeps same gap for reads and writes.
// - Bit 39: host sends 1, answers 0.
// - Five-bit unit index 1..31, echoed back.
// - Address 0x00..0x5F echoed in same bits.
// - Bit 38 one writes; reads ignore data.
// - Write stores 18-bit data into register.
// - Answer carries 18-bit register content.
// - Answer carries 2-bit global fault summary.
// - Six-bit checksum over bits 39..7.
// - Single answers have burst flag zero.
// - Burst codes only as reads, stream answers.
// - Buffer collects burst frames for download.
// - Burst command goes first in its window.
// - Host waits 400 us or 3 ms; dcs_host leaves this wait to software.
// - Intermediate burst frames are not decoded.
// - Final burst frame is decoded, gives last word.
// - Burst answers flag one, then 11 and index.
// - Burst codes 0x78 to 0x7D.
// - Speed setting 11 fast, 00 slow.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dcs_consts.svh"
module dcs_unit import dcs_pkg::*; #(
  parameter int unsigned  NUM_FRAMES = `DCS_BURST_FRAMES,
  parameter logic [4:0]   UNIT_INDEX = 5'h01
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Link pins
  dcs_link_if.unit        link,
  // Device side
  input  wire logic [1:0] global_fault_summary,
  input  wire logic [1:0] link_speed,
  output logic            cmd_dropped,
  output logic            burst_ready
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sck_d;
  always_ff @(posedge clk) begin
    if (reset) begin
      // Reset to the idle pins, select high and clock low, so no false edge follows reset.
      sync_a <= 3'h2;
      sync_b <= 3'h2;
      sck_d  <= 1'b0;
    end else begin
      sync_a <= {link.mosi, link.cs_n, link.sck};
      sync_b <= sync_a;
      sck_d  <= sync_b[0];
    end
  end
  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic sck_rise;
  logic sck_fall;
  assign sck_s    = sync_b[0];
  assign cs_n_s   = sync_b[1];
  assign mosi_s   = sync_b[2];
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter and registers.
  logic [17:0] regs [0:95];
  logic [17:0] burst_mem [0:31];
  logic [39:0] rx_sh, next_rx_sh;
  logic [39:0] tx_sh, next_tx_sh;
  logic [39:0] reply, next_reply;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [4:0]  burst_idx, next_burst_idx;
  logic [4:0]  burst_fill, next_burst_fill;
  logic [6:0]  burst_code, next_burst_code;
  logic        burst_mode, next_burst_mode;
  logic        next_burst_ready;
  logic        next_cmd_dropped;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [17:0] wr_data;
  logic [39:0] frm;
  logic        frame_done;

  assign frm        = {rx_sh[38:0], mosi_s};
  assign frame_done = sck_rise & ~cs_n_s & (bit_cnt == 6'(`DCS_FRAME_BITS - 1));

  function automatic logic [39:0] seal(input logic [39:0] f);
    logic [39:0] r;
    r = f;
    r[`DCS_CRC_HI:`DCS_CRC_LO] = dcs_crc(f);
    return r;
  endfunction : seal

  always_comb begin
    next_rx_sh      = rx_sh;
    next_tx_sh      = tx_sh;
    next_reply      = reply;
    next_bit_cnt    = bit_cnt;
    next_burst_idx  = burst_idx;
    next_burst_fill = burst_fill;
    next_burst_code = burst_code;
    next_burst_mode = burst_mode;
    next_wait_cnt   = wait_cnt;
    next_burst_ready = burst_ready;
    next_cmd_dropped = 1'b0;
    wr_en           = 1'b0;
    wr_addr         = frm[`DCS_ADDR_HI:`DCS_ADDR_LO];
    wr_data         = frm[`DCS_DATA_HI:`DCS_DATA_LO];
    // Burst answers arrive from upstream after a link-speed dependent wait.
    if (burst_fill != 5'(NUM_FRAMES) && burst_code != 7'h00) begin
      if (wait_cnt == 32'h0) begin
        next_burst_fill = burst_fill + 5'h01;
        if (burst_fill == 5'(NUM_FRAMES - 1)) begin
          next_burst_ready = 1'b1;
          // The first download frame must show collected data, not the buffer seen at command time.
          if (burst_mode && burst_idx == 5'h00) begin
            next_reply = seal({1'b0, 1'b1, UNIT_INDEX, burst_code,
                               global_fault_summary, burst_mem[0], 6'h00});
          end
        end
      end else begin
        next_wait_cnt = wait_cnt - 32'h1;
      end
    end
    if (cs_n_s) begin
      next_bit_cnt = 6'h00;
      next_tx_sh   = reply;
      // Raising chip select inside a burst abandons the download.
      if (burst_mode && burst_idx != 5'h00) begin
        next_burst_mode = 1'b0;
      end
    end else if (sck_fall && bit_cnt != 6'h00) begin
      next_tx_sh = {tx_sh[38:0], 1'b0};
    end else if (sck_rise) begin
      next_rx_sh   = frm;
      next_bit_cnt = frame_done ? 6'h00 : bit_cnt + 6'h01;
    end
    if (frame_done) begin
      if (burst_mode && burst_idx != 5'(NUM_FRAMES - 1)) begin
        // Intermediate frames are streamed out without decoding the input.
        next_burst_idx = burst_idx + 5'h01;
        next_reply = seal({1'b0, 1'b1, UNIT_INDEX, 2'b11, burst_idx + 5'h02,
                           global_fault_summary, burst_mem[burst_idx + 5'h01], 6'h00});
        next_tx_sh = next_reply;
        if (burst_idx == 5'(NUM_FRAMES - 2)) begin
          next_burst_mode  = 1'b0;
          next_burst_ready = 1'b0;
        end
      end else if (frm[`DCS_CRC_HI:`DCS_CRC_LO] != dcs_crc(frm) || !frm[`DCS_ORIGIN_BIT]) begin
        next_cmd_dropped = 1'b1;
      end else if (frm[`DCS_UNIT_HI:`DCS_UNIT_LO] != UNIT_INDEX) begin
        next_cmd_dropped = 1'b1;
      end else if (!frm[`DCS_RW_BIT] && frm[`DCS_ADDR_HI:`DCS_ADDR_LO] >= `DCS_BURST_FIRST
                   && frm[`DCS_ADDR_HI:`DCS_ADDR_LO] <= `DCS_BURST_LAST) begin
        // Burst read: the first answer echoes the command code.
        next_burst_code = frm[`DCS_ADDR_HI:`DCS_ADDR_LO];
        next_burst_fill = 5'h00;
        next_burst_ready = 1'b0;
        next_wait_cnt   = (link_speed == `DCS_SPEED_FAST) ? 32'(`DCS_WAIT_FAST_CYC)
                                                          : 32'(`DCS_WAIT_SLOW_CYC);
        next_burst_idx  = 5'h00;
        next_burst_mode = 1'b1;
        next_reply = seal({1'b0, 1'b1, UNIT_INDEX, frm[`DCS_ADDR_HI:`DCS_ADDR_LO],
                           global_fault_summary, burst_mem[0], 6'h00});
      end else if (frm[`DCS_ADDR_HI:`DCS_ADDR_LO] <= `DCS_ADDR_MAX) begin
        wr_en = frm[`DCS_RW_BIT];
        // The answer is built now and held until the next frame.
        next_reply = seal({1'b0, 1'b0, UNIT_INDEX, frm[`DCS_ADDR_HI:`DCS_ADDR_LO], global_fault_summary,
                           frm[`DCS_RW_BIT] ? wr_data : regs[wr_addr], 6'h00});
      end else begin
        next_cmd_dropped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_sh       <= 40'h0;
      tx_sh       <= 40'h0;
      reply       <= 40'h0;
      bit_cnt     <= 6'h00;
      burst_idx   <= 5'h00;
      burst_fill  <= 5'h00;
      burst_code  <= 7'h00;
      burst_mode  <= 1'b0;
      wait_cnt    <= 32'h0;
      burst_ready <= 1'b0;
      cmd_dropped <= 1'b0;
    end else begin
      rx_sh       <= next_rx_sh;
      tx_sh       <= next_tx_sh;
      reply       <= next_reply;
      bit_cnt     <= next_bit_cnt;
      burst_idx   <= next_burst_idx;
      burst_fill  <= next_burst_fill;
      burst_code  <= next_burst_code;
      burst_mode  <= next_burst_mode;
      wait_cnt    <= next_wait_cnt;
      burst_ready <= next_burst_ready;
      cmd_dropped <= next_cmd_dropped;
    end
  end

  // Register array has no reset; a burst frame shows register content of its slot.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
    if (burst_fill != 5'(NUM_FRAMES) && burst_code != 7'h00 && wait_cnt == 32'h0) begin
      burst_mem[burst_fill] <= regs[7'(burst_fill)];
    end
  end

  assign link.miso = tx_sh[39];
endmodule : dcs_unit
